// *** logic/srlp_defs.svh ***
`ifndef SRLP_DEFS_SVH
`define SRLP_DEFS_SVH

`define SRLP_WORD_W        32
`define SRLP_ADDR_W        3
`define SRLP_NUM_LATCH     8
`define SRLP_LATCH_RST     32'h0000_0000
`define SRLP_PWR_LATCH     3'h4
`define SRLP_PWR_MSB       4
`define SRLP_PWR_LSB       3
`define SRLP_MUX_LATCH     3'h2
`define SRLP_MUX_MSB       28
`define SRLP_MUX_LSB       26
`define SRLP_MUX_LOCK      3'h6

`endif

// *** logic/srlp_pkg.sv ***
package srlp_pkg;
    `include "srlp_defs.svh"

    typedef logic [`SRLP_ADDR_W-1:0] srlp_addr_t;

    typedef struct packed {
        logic [`SRLP_WORD_W-1:`SRLP_ADDR_W] data;
        srlp_addr_t                         addr;
    } srlp_word_t;

    typedef enum logic [1:0] {
        SRLP_ST_IDLE = 2'h0,
        SRLP_ST_LOAD = 2'h1
    } srlp_state_t;
endpackage : srlp_pkg

// *** logic/srlp_latch_mem.sv ***
`timescale 1ns/100ps
module srlp_latch_mem
    import srlp_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_wr_en,
    input  wire srlp_word_t i_wr_word,
    input  wire srlp_addr_t i_rd_addr,
    output srlp_word_t      o_rd_word
);
    srlp_word_t mem_q [`SRLP_NUM_LATCH];

    genvar g;
    generate
        for (g = 0; g < `SRLP_NUM_LATCH; g++) begin : g_latch
            always_ff @(posedge i_core_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    mem_q[g] <= `SRLP_LATCH_RST;
                end else if (i_wr_en && i_wr_word.addr == srlp_addr_t'(g)) begin
                    mem_q[g] <= i_wr_word;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_word <= `SRLP_LATCH_RST;
        end else begin
            o_rd_word <= mem_q[i_rd_addr];
        end
    end
endmodule : srlp_latch_mem

// *** logic/srlp_load_port.sv ***
// Behaviour
// [RULE_01] sample data on every serial clock rise
// [RULE_02] strobe rise moves 32 bits into latch
// [RULE_03] controller lowers strobe before shifting
// [RULE_04] controller sends full word, maybe four bytes
// [RULE_05] controller raises strobe after last bit
// [RULE_06] controller uses clock phase zero
// [RULE_07] port is write only, no readback
// [RULE_08] output power from latch 4 bits 4:3
// [RULE_09] power-down input, lock status on mux output
// [RULE_10] msb first, low bits hold latch address
`timescale 1ns/100ps
module srlp_load_port
    import srlp_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_arst_n,
    input  wire logic       i_serial_clk,
    input  wire logic       i_serial_data,
    input  wire logic       i_load_strobe,
    input  wire logic       i_chip_enable,
    input  wire logic       i_lock_detect,
    output logic            o_powered_down,
    output logic [1:0]      o_rf_power_sel,
    output logic            o_multiplexed_status_output,
    output logic            o_word_loaded
);
    ////////////////////////////////////////////////////////////////////
    // serial clock domain: shifter has no reset of its own
    logic [`SRLP_WORD_W-1:0] shift_q;

    always_ff @(posedge i_serial_clk) begin
        shift_q <= {shift_q[`SRLP_WORD_W-2:0], i_serial_data}; // RULE_01 RULE_10
    end

    ////////////////////////////////////////////////////////////////////
    // crossings: strobe is a level, two flops before any logic
    logic strobe_s1_q;
    logic strobe_s2_q;
    logic strobe_s3_q;
    logic ce_s1_q;
    logic ce_s2_q;
    logic lock_s1_q;
    logic lock_s2_q;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            strobe_s1_q <= 1'h0;
            strobe_s2_q <= 1'h0;
            strobe_s3_q <= 1'h0;
        end else begin
            strobe_s1_q <= i_load_strobe;
            strobe_s2_q <= strobe_s1_q;
            strobe_s3_q <= strobe_s2_q;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ce_s1_q   <= 1'h0;
            ce_s2_q   <= 1'h0;
            lock_s1_q <= 1'h0;
            lock_s2_q <= 1'h0;
        end else begin
            ce_s1_q   <= i_chip_enable;
            ce_s2_q   <= ce_s1_q;
            lock_s1_q <= i_lock_detect;
            lock_s2_q <= lock_s1_q;
        end
    end

    // shift_q is stable while strobe is high (no clocks then), so
    // sampling it on the third core clock edge after the rise is safe
    logic strobe_rise;
    assign strobe_rise = strobe_s2_q && !strobe_s3_q;

    ////////////////////////////////////////////////////////////////////
    // transfer into the addressed latch
    srlp_word_t cap_word;
    assign cap_word = srlp_word_t'(shift_q);

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_word_loaded <= 1'h0;
        end else begin
            o_word_loaded <= strobe_rise; // RULE_02
        end
    end

    // latch 4 and latch 2 shadows feed the output registers
    logic [1:0] pwr_q;
    logic [2:0] mux_q;

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pwr_q <= 2'h0;
        end else if (strobe_rise && cap_word.addr == `SRLP_PWR_LATCH) begin
            pwr_q <= shift_q[`SRLP_PWR_MSB:`SRLP_PWR_LSB]; // RULE_08
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mux_q <= 3'h0;
        end else if (strobe_rise && cap_word.addr == `SRLP_MUX_LATCH) begin
            mux_q <= shift_q[`SRLP_MUX_MSB:`SRLP_MUX_LSB];
        end
    end

    // full latch bank kept for the synthesizer core; nothing reads it back
    // over the serial pins, the port has no data output at all
    srlp_latch_mem u_mem (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_wr_en    (strobe_rise), // RULE_02 RULE_07
        .i_wr_word  (cap_word),
        .i_rd_addr  (`SRLP_PWR_LATCH),
        .o_rd_word  ()
    );

    ////////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_powered_down              <= 1'h1;
            o_rf_power_sel              <= 2'h0;
            o_multiplexed_status_output <= 1'h0;
        end else begin
            o_powered_down              <= !ce_s2_q; // RULE_09
            o_rf_power_sel              <= pwr_q;
            o_multiplexed_status_output <= (mux_q == `SRLP_MUX_LOCK) && lock_s2_q; // RULE_09
        end
    end

    ////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_strobe_edge;
        strobe_s2_q && !strobe_s3_q;
    endsequence

    AST_LOAD_PULSE: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE_02
        s_strobe_edge |=> o_word_loaded ##1 !o_word_loaded)
        else $error("load pulse missing or too long");

    AST_PWR_FIELD: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE_08
        (s_strobe_edge and cap_word.addr == 3'h4) |=>
            ##1 o_rf_power_sel == $past(shift_q[4:3], 2))
        else $error("power field not applied");

    AST_PWR_HOLD: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE_08
        !strobe_rise |=> ##1 $stable(o_rf_power_sel) || $past(strobe_rise, 2))
        else $error("power select changed without load");

    AST_PDN: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE_09
        !ce_s2_q |=> o_powered_down)
        else $error("power down not asserted");

    AST_MUX_LOCK: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE_09
        (mux_q == 3'h6 && lock_s2_q) |=> o_multiplexed_status_output)
        else $error("lock not shown on mux output");

    AST_MUX_OFF: assert property (@(posedge i_core_clk) disable iff (!i_arst_n) // RULE_09
        (mux_q != 3'h6) |=> !o_multiplexed_status_output)
        else $error("mux output high when not lock mode");

    AST_SHIFT: assert property (@(posedge i_serial_clk) // RULE_01
        ##1 shift_q[0] == $past(i_serial_data))
        else $error("serial bit not sampled");

    AST_MSB_FIRST: assert property (@(posedge i_serial_clk) // RULE_10
        ##1 shift_q[31:1] == $past(shift_q[30:0]))
        else $error("shift order broken");
endmodule : srlp_load_port

// *** testbench/srlp_ctrl_model.sv ***
`timescale 1ns/100ps
module srlp_ctrl_model (
    output logic o_serial_clk,
    output logic o_serial_data,
    output logic o_load_strobe
);
    initial begin
        o_serial_clk  = 1'b0;
        o_serial_data = 1'b0;
        o_load_strobe = 1'b1;
    end
    // clock idles low between frames
    task automatic send_word(input logic [31:0] w);
        o_load_strobe = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            o_serial_data = w[i];
            #15 o_serial_clk = 1'b1;
            #15 o_serial_clk = 1'b0;
            if (i % 8 == 0) #40;
        end
        o_serial_data = ~w[0];
        o_load_strobe = 1'b1;
    endtask : send_word
endmodule : srlp_ctrl_model

// *** testbench/srlp_load_port_tb.sv ***
`timescale 1ns/100ps
module srlp_load_port_tb;
    import srlp_pkg::*;
    logic       clk     = 1'b0;
    logic       arst_n  = 1'b0;
    logic       chip_en = 1'b1;
    logic       lock    = 1'b0;
    logic       sclk, sdata, strobe, pdn, mux, loaded;
    logic [1:0] pwr;
    int         failures   = 0;
    int         n_compared = 0;
    initial forever #12.5 clk = ~clk;
    srlp_ctrl_model u_srlp_ctrl_model (.o_serial_clk(sclk), .o_serial_data(sdata), .o_load_strobe(strobe));
    srlp_load_port u_srlp_load_port (
        .i_core_clk(clk), .i_arst_n(arst_n), .i_serial_clk(sclk), .i_serial_data(sdata),
        .i_load_strobe(strobe), .i_chip_enable(chip_en), .i_lock_detect(lock),
        .o_powered_down(pdn), .o_rf_power_sel(pwr), .o_multiplexed_status_output(mux), .o_word_loaded(loaded));
    ////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim
    // strobe stays high well past the sync delay
    task automatic load(input logic [31:0] w);
        int k;
        u_srlp_ctrl_model.send_word(w);
        for (k = 0; k < 8 && loaded !== 1'b1; k++) @(negedge clk);
        check("loaded", loaded, 1);
        if (k == 8) end_sim();
        @(negedge clk);
        check("loaded pulse", loaded, 0);
        repeat (4) @(negedge clk);
    endtask : load
    task automatic t_pdn;
        @(posedge clk) chip_en <= 1'b0;
        repeat (4) @(negedge clk);
        check("powered_down", pdn, 1);
        @(posedge clk) chip_en <= 1'b1;
        repeat (4) @(negedge clk);
        check("powered_down", pdn, 0);
    endtask : t_pdn
    task automatic t_power;
        for (int s = 0; s < 4; s++) begin
            load({24'hC3A5C3, 3'h7, s[1:0], 3'h4});
            check("rf_power_sel", pwr, s);
        end
        // same field, other latch: must not leak
        load({24'h0, 3'h0, 2'h0, 3'h5});
        check("rf_power_sel", pwr, 3);
    endtask : t_power
    task automatic t_mux;
        load({3'h7, 3'h6, 23'h0, 3'h2});
        @(posedge clk) lock <= 1'b1;
        repeat (4) @(negedge clk);
        check("mux", mux, 1);
        @(posedge clk) lock <= 1'b0;
        repeat (4) @(negedge clk);
        check("mux", mux, 0);
        @(posedge clk) lock <= 1'b1;
        load({3'h0, 3'h5, 23'h7FFFFF, 3'h2});
        check("mux", mux, 0);
    endtask : t_mux
    initial begin
        repeat (5) @(posedge clk);
        check("powered_down", pdn, 1);
        check("rf_power_sel", pwr, 0);
        arst_n <= 1'b1;
        t_pdn();
        t_power();
        t_mux();
        end_sim();
    end
endmodule : srlp_load_port_tb
